// ---- design/pkim_pkg.sv ----
// Constants, register map and types for the key-unit interrupt mask block
package pkim_pkg;

    // Host word addresses (byte offsets)
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_MASK      = 8'h08;
    localparam logic [7:0] ADDR_EXPSCALAR = 8'h0C;

    // Bit positions in status; DONE, OOB and ERDY are also mask bits, IE is the control bit
    localparam int BIT_DONE = 0;
    localparam int BIT_ERR  = 1;
    localparam int BIT_IRQ  = 3;
    localparam int BIT_OOB  = 2;
    localparam int BIT_ERDY = 4;
    localparam int BIT_IE   = 0;

    localparam logic [15:0] MASK_DEFINED = 16'h0015;
    localparam logic [15:0] IRQ_SOURCES  = 16'h0017;
    localparam logic [15:0] MASK_RESET   = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic        IE_RESET     = 1'b0;

    // Boot procedure: one cycle per embedded RAM word cleared
    localparam int          BOOT_WORDS   = 128;
    localparam logic [7:0]  BOOT_LAST    = 8'(BOOT_WORDS - 1);

    typedef enum logic [0:0] {
        PKIM_BOOT = 1'b0,
        PKIM_RUN  = 1'b1
    } pkim_state_t;

    typedef enum logic [2:0] {
        SEL_CONTROL = 3'h0,
        SEL_STATUS  = 3'h1,
        SEL_MASK    = 3'h2,
        SEL_EXP     = 3'h3,
        SEL_NONE    = 3'h4
    } pkim_sel_t;

endpackage

// ---- design/pkim_top.sv ----
// Interrupt mask, status flags and IRQ generation for the key unit
`timescale 1ns/1ps
module pkim_top
    import pkim_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Host parallel bus
    input  wire logic        host_cs_i,
    input  wire logic        host_rd_i,
    input  wire logic        host_wr_i,
    input  wire logic [7:0]  host_addr_i,
    input  wire logic [31:0] host_wdata_i,
    output logic      [31:0] host_rdata_o,
    output logic             host_rvalid_o,
    // Arithmetic core events
    input  wire logic        exp_req_i,
    input  wire logic        branch_zero_i,
    input  wire logic        gen_error_i,
    // Exponent or scalar word to the core
    output logic      [31:0] exp_word_o,
    output logic             exp_word_valid_o,
    // Status
    output logic             boot_busy_o,
    output logic             irq_o
);
    import pkim_pkg::*;

    function automatic pkim_sel_t decode(input logic [7:0] addr);
        pkim_sel_t s;
        s = SEL_NONE;
        case (addr)
            ADDR_CONTROL:   s = SEL_CONTROL;
            ADDR_STATUS:    s = SEL_STATUS;
            ADDR_MASK:      s = SEL_MASK;
            ADDR_EXPSCALAR: s = SEL_EXP;
            default:        s = SEL_NONE;
        endcase
        return s;
    endfunction

    pkim_sel_t   sel;
    logic        acc;
    logic        wr_any;
    logic        rd_any;
    logic        bad_acc;

    assign sel     = decode(host_addr_i);
    assign rd_any  = host_cs_i & host_rd_i;
    assign wr_any  = host_cs_i & host_wr_i;
    assign acc     = rd_any | wr_any;
    assign bad_acc = acc & (sel == SEL_NONE);

    // Register state
    logic [15:0] mask_reg,     mask_next;
    logic [15:0] status_reg,   status_next;
    logic        ie_reg,       ie_next;
    logic        exp_clr_reg,  exp_clr_next;
    logic        irq_raw_reg,  irq_raw_next;
    logic        irq_reg,      irq_next;
    logic [31:0] rdata_reg,    rdata_next;
    logic        rvalid_reg,   rvalid_next;
    logic [31:0] expw_reg,     expw_next;
    logic        expv_reg,     expv_next;
    pkim_state_t state_reg,    state_next;
    logic [7:0]  boot_cnt_reg, boot_cnt_next;
    logic        busy_reg,     busy_next;
    logic        boot_fin;

    // Boot sequencer
    always_comb
    begin
        state_next    = state_reg;
        boot_cnt_next = boot_cnt_reg;
        boot_fin      = 1'b0;
        case (state_reg)
            PKIM_BOOT:
            begin
                boot_cnt_next = boot_cnt_reg + 8'h01;
                if (boot_cnt_reg == BOOT_LAST)
                begin
                    boot_fin   = 1'b1;
                    state_next = PKIM_RUN;
                end
            end
            PKIM_RUN:
            begin
                boot_cnt_next = boot_cnt_reg;
            end
            default:
            begin
                state_next = PKIM_BOOT;
            end
        endcase
        // Busy flag follows the state about to be entered
        busy_next = (state_next == PKIM_BOOT);
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_reg    <= PKIM_BOOT;
            boot_cnt_reg <= 8'h00;
            busy_reg     <= 1'b1;
        end
        else
        begin
            state_reg    <= state_next;
            boot_cnt_reg <= boot_cnt_next;
            busy_reg     <= busy_next;
        end
    end

    // Host registers, status flags and IRQ
    always_comb
    begin
        mask_next    = mask_reg;
        ie_next      = ie_reg;
        status_next  = status_reg;
        exp_clr_next = 1'b0;
        expw_next    = expw_reg;
        expv_next    = 1'b0;
        rdata_next   = rdata_reg;
        rvalid_next  = 1'b0;

        if (wr_any)
        begin
            case (sel)
                SEL_CONTROL: ie_next = host_wdata_i[BIT_IE];
                SEL_MASK:
                begin
                    // Only defined bits are stored
                    mask_next = host_wdata_i[15:0]
                                & MASK_DEFINED;
                end
                SEL_STATUS:  status_next = STATUS_RESET;
                SEL_EXP:
                begin
                    expw_next    = host_wdata_i;
                    expv_next    = 1'b1;
                    exp_clr_next = 1'b1;
                end
                default:     mask_next = mask_reg;
            endcase
        end

        // Delayed clear of the request flag
        if (exp_clr_reg)
            status_next[BIT_ERDY] = 1'b0;

        // Sets win over any clear in the same cycle
        if (exp_req_i)
            status_next[BIT_ERDY] = 1'b1;
        if (bad_acc)
            status_next[BIT_OOB] = 1'b1;
        if (branch_zero_i || boot_fin)
            status_next[BIT_DONE] = 1'b1;
        if (gen_error_i)
            status_next[BIT_ERR] = 1'b1;
        status_next[BIT_IRQ] = 1'b0;

        irq_raw_next = |(status_reg & IRQ_SOURCES
                         & ~mask_reg);
        irq_next     = irq_raw_next & ie_reg;

        if (rd_any)
        begin
            rvalid_next = 1'b1;
            case (sel)
                SEL_CONTROL: rdata_next = {31'h0, ie_reg};
                SEL_STATUS:
                begin
                    rdata_next          = {16'h0000, status_reg};
                    rdata_next[BIT_IRQ] = irq_raw_reg;
                end
                SEL_MASK:    rdata_next = {16'h0000, mask_reg};
                default:     rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mask_reg    <= MASK_RESET;
            ie_reg      <= IE_RESET;
            status_reg  <= STATUS_RESET;
            exp_clr_reg <= 1'b0;
            irq_raw_reg <= 1'b0;
            irq_reg     <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rvalid_reg  <= 1'b0;
            expw_reg    <= 32'h0000_0000;
            expv_reg    <= 1'b0;
        end
        else
        begin
            mask_reg    <= mask_next;
            ie_reg      <= ie_next;
            status_reg  <= status_next;
            exp_clr_reg <= exp_clr_next;
            irq_raw_reg <= irq_raw_next;
            irq_reg     <= irq_next;
            rdata_reg   <= rdata_next;
            rvalid_reg  <= rvalid_next;
            expw_reg    <= expw_next;
            expv_reg    <= expv_next;
        end
    end

    assign host_rdata_o     = rdata_reg;
    assign host_rvalid_o    = rvalid_reg;
    assign exp_word_o       = expw_reg;
    assign exp_word_valid_o = expv_reg;
    assign irq_o            = irq_reg;
    assign boot_busy_o      = busy_reg;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    logic quiet;
    assign quiet = !exp_req_i && !branch_zero_i && !gen_error_i && !host_cs_i
                   && (state_reg == PKIM_RUN);

    sequence s_exp_write_alone;
        wr_any && sel == SEL_EXP && quiet == 1'b0 && !exp_req_i
            && !branch_zero_i && !gen_error_i
            && (status_reg & IRQ_SOURCES & ~(16'h0001 << BIT_ERDY)) == 16'h0000
            && state_reg == PKIM_RUN;
    endsequence

    sequence s_quiet2;
        quiet [*2];
    endsequence

    AST_MASK_WRITE: assert property (
        wr_any && sel == SEL_MASK |=>
            mask_reg == ($past(host_wdata_i[15:0]) & MASK_DEFINED))
        else $error("mask did not take written value");

    AST_MASK_RSV_ZERO: assert property (
        (mask_reg & ~MASK_DEFINED) == 16'h0000)
        else $error("reserved mask bit is set");

    AST_MASK_READ: assert property (
        rd_any && sel == SEL_MASK && !wr_any |=>
            host_rvalid_o && host_rdata_o == {16'h0000, $past(mask_reg)})
        else $error("mask read data wrong");

    AST_IRQ_NEEDS_IE: assert property (
        irq_o |-> $past(ie_reg))
        else $error("irq high without global enable");

    AST_IRQ_LEVEL: assert property (
        ie_reg && status_reg[BIT_DONE] && !mask_reg[BIT_DONE]
            |=> irq_o)
        else $error("unmasked done did not raise irq");

    AST_MASKED_SILENT: assert property (
        (status_reg & IRQ_SOURCES & ~mask_reg) == 16'h0000 |=> !irq_raw_reg)
        else $error("masked status raised irq");

    AST_ERDY_SET: assert property (
        exp_req_i |=> status_reg[BIT_ERDY])
        else $error("exponent request flag not set");

    AST_EXP_CLEAR: assert property (
        wr_any && sel == SEL_EXP && !exp_req_i ##1 !exp_req_i
            |=> !status_reg[BIT_ERDY])
        else $error("exponent write did not clear request flag");

    AST_IRQ_TWO_CYCLE: assert property (
        s_exp_write_alone ##1 s_quiet2 |=> !irq_o)
        else $error("irq not released two cycles after exponent write");

    AST_OOB_SET: assert property (
        bad_acc |=> status_reg[BIT_OOB])
        else $error("out-of-bounds flag not set");

    AST_DONE_SET: assert property (
        branch_zero_i |=> status_reg[BIT_DONE])
        else $error("completion flag not set on branch to zero");

    AST_BOOT_DONE: assert property (
        state_reg == PKIM_BOOT ##1 state_reg == PKIM_RUN
            |-> status_reg[BIT_DONE] && !boot_busy_o)
        else $error("completion flag missing after boot");

    AST_IRQ_MIRROR: assert property (
        irq_o |-> $past(irq_raw_next))
        else $error("status irq bit does not mirror output");

    AST_STATUS_CLEAR: assert property (
        wr_any && sel == SEL_STATUS && !exp_req_i && !branch_zero_i
            && !gen_error_i && !boot_fin
            |=> (status_reg & IRQ_SOURCES) == 16'h0000)
        else $error("status write did not clear flags");

    AST_EXP_WORD: assert property (
        wr_any && sel == SEL_EXP |=>
            exp_word_valid_o && exp_word_o == $past(host_wdata_i))
        else $error("exponent word not passed on");

    AST_IRQ_RELEASE: assert property (
        (status_reg & IRQ_SOURCES & ~mask_reg) == 16'h0000 |=> !irq_o)
        else $error("irq high with no unmasked source");

endmodule

// ---- dv/pkim_host_model.sv ----
// Host processor model driving the parallel register bus
`timescale 1ns/1ps
module pkim_host_model
(
    // Clock
    input  wire logic        clk_i,
    // Bus to the unit
    output logic             cs_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic [7:0]       addr_o,
    output logic [31:0]      wdata_o,
    input  wire logic [31:0] rdata_i,
    input  wire logic        rvalid_i
);
    initial
    begin
        cs_o    = 1'b0;
        rd_o    = 1'b0;
        wr_o    = 1'b0;
        addr_o  = 8'hFF;
        wdata_o = 32'hFFFFFFFF;
    end

    // One-cycle access; released address and data show the inverse value, controls go low
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cs_o    <= 1'b1;
        rd_o    <= ~w;
        wr_o    <= w;
        addr_o  <= a;
        wdata_o <= d;
        @(posedge clk_i);
        cs_o    <= 1'b0;
        rd_o    <= 1'b0;
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
        #1;
        q = (rvalid_i === 1'b1) ? rdata_i : 32'hFFFFFFFF;
    endtask
endmodule

// ---- dv/pkim_top_bench.sv ----
// Self-checking bench for the key-unit interrupt mask block
`timescale 1ns/1ps
module pkim_top_bench;
    import pkim_pkg::*;
    logic        clk_i, resetn_i, cs, rd, wr, rvalid, exp_req, br0, gerr;
    logic        ev, busy, irq, ie, u;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, xw, q, d, m;
    int          checked, num_errors, cycles, i, k;
    localparam int EVBIT [4] = '{BIT_DONE, BIT_ERR, BIT_OOB, BIT_ERDY};

    pkim_host_model h (.clk_i(clk_i), .cs_o(cs), .rd_o(rd), .wr_o(wr),
        .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
    pkim_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .host_cs_i(cs),
        .host_rd_i(rd), .host_wr_i(wr), .host_addr_i(addr),
        .host_wdata_i(wdata), .host_rdata_o(rdata), .host_rvalid_o(rvalid),
        .exp_req_i(exp_req), .branch_zero_i(br0), .gen_error_i(gerr),
        .exp_word_o(xw), .exp_word_valid_o(ev), .boot_busy_o(busy),
        .irq_o(irq));

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask

    // Defined mask bits are exponent request, out of bounds, completion
    function automatic logic [31:0] want_mask(input logic [31:0] w);
        return w & ((32'h1 << BIT_ERDY) | (32'h1 << BIT_OOB)
                    | (32'h1 << BIT_DONE));
    endfunction

    function automatic logic [31:0] want_st(input int k, input logic u);
        return (32'h1 << EVBIT[k]) | ({31'h0, u} << BIT_IRQ);
    endfunction

    task automatic wrr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] r;
        h.xfer(1'b1, a, v, r);
    endtask

    // Core event or unmapped access, then let flags and IRQ settle
    task automatic pulse(input int e);
        if (e == 2)
            h.xfer(1'b0, 8'h40, 32'h0, q);
        else
        begin
            @(posedge clk_i);
            br0     <= (e == 0);
            gerr    <= (e == 1);
            exp_req <= (e == 3);
            @(posedge clk_i);
            br0     <= 1'b0;
            gerr    <= 1'b0;
            exp_req <= 1'b0;
        end
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    initial
    begin
        resetn_i = 1'b0;
        exp_req  = 1'b0;
        br0      = 1'b0;
        gerr     = 1'b0;
        void'($urandom(44));
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1;
        chk("boot_busy", 32'h1, {31'h0, busy});
        for (i = 0; i < 300 && busy !== 1'b0; i++)
            @(posedge clk_i);
        h.xfer(1'b0, ADDR_STATUS, 32'h0, q);
        chk("boot_status", 32'h9, q);
        h.xfer(1'b0, ADDR_MASK, 32'h0, q);
        chk("mask_reset", 32'h0, q);
        for (i = 0; i < 6; i++)
        begin
            d = (i == 0) ? 32'hFFFFFFFF : $urandom;
            wrr(ADDR_MASK, d);
            h.xfer(1'b0, ADDR_MASK, 32'h0, q);
            chk("mask", want_mask(d), q);
        end
        for (i = 0; i < 14; i++)
        begin
            k  = (i < 4) ? i : $urandom_range(3);
            m  = (i < 4) ? 32'h0 : ($urandom & 32'h15);
            ie = (i < 4) ? 1'b1 : 1'($urandom_range(1));
            wrr(ADDR_MASK, m);
            wrr(ADDR_CONTROL, {31'h0, ie});
            wrr(ADDR_STATUS, 32'h0);
            pulse(k);
            u = (k == 1) || !m[EVBIT[k]];
            chk_bit("irq", ie & u, irq);
            h.xfer(1'b0, ADDR_STATUS, 32'h0, q);
            chk("status", want_st(k, u), q);
            chk_bit("irq_bit", u, q[BIT_IRQ]);
        end
        for (i = 0; i < 2; i++)
        begin
            wrr(ADDR_CONTROL, 32'h1);
            wrr(ADDR_MASK, 32'h0);
            wrr(ADDR_STATUS, 32'h0);
            if (i == 1)
                pulse(0);
            pulse(3);
            d = $urandom;
            h.xfer(1'b1, ADDR_EXPSCALAR, d, q);
            chk("exp_valid", 32'h1, {31'h0, ev});
            chk("exp_word", d, xw);
            chk("irq_hold", 32'h1, {31'h0, irq});
            repeat (2) @(posedge clk_i);
            #1;
            chk_bit("irq_after", i[0], irq);
            h.xfer(1'b0, ADDR_STATUS, 32'h0, q);
            chk("erdy_clear", (i == 1) ? 32'h9 : 32'h0, q);
        end
        // Host that ignores the request masks it
        wrr(ADDR_MASK, 32'h10);
        wrr(ADDR_STATUS, 32'h0);
        pulse(3);
        chk_bit("irq_masked", 1'b0, irq);
        h.xfer(1'b0, ADDR_CONTROL, 32'h0, q);
        chk("control", 32'h1, q);
        h.xfer(1'b0, ADDR_EXPSCALAR, 32'h0, q);
        chk("exp_read", 32'h0, q);
        h.xfer(1'b0, ADDR_STATUS, 32'h0, q);
        chk("status_masked", 32'h1 << BIT_ERDY, q);
        // Unmapped write sets out of bounds as well
        wrr(8'h40, 32'h0);
        h.xfer(1'b0, ADDR_STATUS, 32'h0, q);
        d = want_st(2, 1'b1) | (32'h1 << BIT_ERDY);
        chk("oob_write", d, q);
        finish_test();
    end
endmodule
